//--- rtl/tdc_apll_and_sysclk_divider_cfg.v
// Converter reference, feedback modulator, DAC baseline and system clock divider
//
// Overview of operation
// - Pre-divide code 0..4 bypasses or divides 2-16
// - Reference select picks reference input or clock pin
// - Modulator enable chooses integer or modulated division
// - Order field: integer, first, second; 3 reserved
// - Feedback integer is 8-bit, resets to 0x23
// - Fraction is field over two to sixteenth
// - DAC input is baseline plus DAC modulation input
// - System clock is oscillator over 4 over integer
`timescale 1ns/1ps
`include "tdc_cfg_defs.vh"
module tdc_apll_and_sysclk_divider_cfg (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Register access from the serial port engine
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // Reference pins and selection
  input wire i_ref_in,
  input wire i_clkin,
  input wire i_apll_ref_sel,
  output reg o_ref_div_pulse,
  output reg o_ref_div_clk,
  // Feedback divider
  input wire i_fb_strobe,
  output reg [9:0] o_fb_divide,
  // DAC
  input wire [4:0] i_dac_modulation,
  output reg [5:0] o_dac_code,
  // System clock divider
  input wire i_osc_tick,
  output reg o_sys_tick,
  // Configuration view
  output reg o_fb_modulator_enable,
  output reg [1:0] o_fb_modulator_order
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Codes above 4 are undefined; clamp to the deepest ratio
  function [7:0] predivide_ratio;
    input [2:0] code;
    begin
      case (code)
        3'h0: predivide_ratio = 8'h01;
        3'h1: predivide_ratio = 8'h02;
        3'h2: predivide_ratio = 8'h04;
        3'h3: predivide_ratio = 8'h08;
        default: predivide_ratio = 8'h10;
      endcase
    end
  endfunction

  function rising;
    input now;
    input prev;
    begin
      rising = now & ~prev;
    end
  endfunction

  // Oscillator edges per system tick; prescale is folded into the count
  function [7:0] sys_ratio;
    input [4:0] div;
    begin
      sys_ratio = `SYS_PRESCALE * {3'h0, div};
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [2:0] ref_predivide_r;
  reg fb_modulator_enable_r;
  reg [1:0] fb_modulator_order_r;
  reg [7:0] fb_divide_integer_r;
  reg [15:0] fb_divide_fraction_r;
  reg [4:0] dac_baseline_r;
  reg [4:0] sys_divide_r;
  reg [2:0] ref_predivide_nxt;
  reg fb_modulator_enable_nxt;
  reg [1:0] fb_modulator_order_nxt;
  reg [7:0] fb_divide_integer_nxt;
  reg [15:0] fb_divide_fraction_nxt;
  reg [4:0] dac_baseline_nxt;
  reg [4:0] sys_divide_nxt;
  reg [7:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Out-of-range baseline and divide codes are stored as written
  always @* begin
    ref_predivide_nxt = ref_predivide_r;
    fb_modulator_enable_nxt = fb_modulator_enable_r;
    fb_modulator_order_nxt = fb_modulator_order_r;
    fb_divide_integer_nxt = fb_divide_integer_r;
    fb_divide_fraction_nxt = fb_divide_fraction_r;
    dac_baseline_nxt = dac_baseline_r;
    sys_divide_nxt = sys_divide_r;
    if (i_wr_en) begin
      case (i_addr)
        `ADDR_REF_PREDIVIDE: begin
          ref_predivide_nxt = i_wdata[`PREDIV_MSB:0];
        end
        `ADDR_FB_MOD_CTRL: begin
          fb_modulator_enable_nxt = i_wdata[`MOD_EN_BIT];
          fb_modulator_order_nxt = i_wdata[`MOD_ORDER_MSB:0];
        end
        `ADDR_FB_INTEGER: begin
          fb_divide_integer_nxt = i_wdata;
        end
        // Bytes land one at a time; a half-written fraction is live
        `ADDR_FB_FRAC_LO: begin
          fb_divide_fraction_nxt[7:0] = i_wdata;
        end
        `ADDR_FB_FRAC_HI: begin
          fb_divide_fraction_nxt[15:8] = i_wdata;
        end
        `ADDR_DAC_BASELINE: begin
          dac_baseline_nxt = i_wdata[`DAC_BASE_MSB:0];
        end
        `ADDR_SYS_DIVIDE: begin
          sys_divide_nxt = i_wdata[`SYS_DIV_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_predivide_r <= `RST_PREDIV;
      fb_modulator_enable_r <= `RST_MOD_EN;
      fb_modulator_order_r <= `RST_MOD_ORDER;
      fb_divide_integer_r <= `RST_FB_INTEGER;
      fb_divide_fraction_r <= `RST_FB_FRAC;
      dac_baseline_r <= `RST_DAC_BASE;
      sys_divide_r <= `RST_SYS_DIV;
    end else begin
      ref_predivide_r <= ref_predivide_nxt;
      fb_modulator_enable_r <= fb_modulator_enable_nxt;
      fb_modulator_order_r <= fb_modulator_order_nxt;
      fb_divide_integer_r <= fb_divide_integer_nxt;
      fb_divide_fraction_r <= fb_divide_fraction_nxt;
      dac_baseline_r <= dac_baseline_nxt;
      sys_divide_r <= sys_divide_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always @* begin
    case (i_addr)
      `ADDR_REF_PREDIVIDE: rdata_nxt = {5'h00, ref_predivide_r};
      `ADDR_FB_MOD_CTRL: rdata_nxt = {fb_modulator_enable_r, 5'h00, fb_modulator_order_r};
      `ADDR_FB_INTEGER: rdata_nxt = fb_divide_integer_r;
      `ADDR_FB_FRAC_LO: rdata_nxt = fb_divide_fraction_r[7:0];
      `ADDR_FB_FRAC_HI: rdata_nxt = fb_divide_fraction_r[15:8];
      `ADDR_DAC_BASELINE: rdata_nxt = {3'h0, dac_baseline_r};
      `ADDR_SYS_DIVIDE: rdata_nxt = {3'h0, sys_divide_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data holds between strobes so a slow port can fetch it
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      o_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reference synchronisers and selection
  // ----------------------------------------------------------------
  reg [1:0] ref_sync_r;
  reg [1:0] clkin_sync_r;
  reg ref_prev_r;
  reg clkin_prev_r;
  reg osc_sync1_r;
  reg osc_sync2_r;
  reg osc_prev_r;
  reg sel_edge;
  wire ref_div_pulse;
  wire sys_pulse;
  wire [9:0] fb_divide;

  // Pin edges are only seen if the pin toggles slower than half i_clk
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_sync_r <= 2'b00;
      clkin_sync_r <= 2'b00;
      ref_prev_r <= 1'b0;
      clkin_prev_r <= 1'b0;
      osc_sync1_r <= 1'b0;
      osc_sync2_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      ref_sync_r <= {ref_sync_r[0], i_ref_in};
      clkin_sync_r <= {clkin_sync_r[0], i_clkin};
      ref_prev_r <= ref_sync_r[1];
      clkin_prev_r <= clkin_sync_r[1];
      osc_sync1_r <= i_osc_tick;
      osc_sync2_r <= osc_sync1_r;
      osc_prev_r <= osc_sync2_r;
    end
  end

  // Select is a same-clock level; switching it may drop or add one edge
  always @* begin
    if (i_apll_ref_sel) begin
      sel_edge = rising(clkin_sync_r[1], clkin_prev_r);
    end else begin
      sel_edge = rising(ref_sync_r[1], ref_prev_r);
    end
  end

  // ----------------------------------------------------------------
  // Dividers and modulator
  // ----------------------------------------------------------------
  edge_divider u_ref_prediv (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_bypass(ref_predivide_r == `PREDIV_BYPASS),
    .i_ratio(predivide_ratio(ref_predivide_r)),
    .i_pulse(sel_edge),
    .o_pulse(ref_div_pulse)
  );

  edge_divider u_sys_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_bypass(1'b0),
    .i_ratio(sys_ratio(sys_divide_r)),
    .i_pulse(rising(osc_sync2_r, osc_prev_r)),
    .o_pulse(sys_pulse)
  );

  // Modulator advances only on feedback strobes
  fb_modulator u_fb_mod (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_enable(fb_modulator_enable_r),
    .i_order(fb_modulator_order_r),
    .i_integer(fb_divide_integer_r),
    .i_fraction(fb_divide_fraction_r),
    .i_fb_strobe(i_fb_strobe),
    .o_divide(fb_divide)
  );

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Extra stage costs one cycle but keeps every output on a flop here
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ref_div_pulse <= 1'b0;
      o_ref_div_clk <= 1'b0;
      o_sys_tick <= 1'b0;
    end else begin
      o_ref_div_pulse <= ref_div_pulse;
      if (ref_div_pulse) begin
        o_ref_div_clk <= ~o_ref_div_clk;
      end
      o_sys_tick <= sys_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Feedback, DAC and configuration view
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fb_divide <= {2'b00, `RST_FB_INTEGER};
      o_dac_code <= 6'h00;
      o_fb_modulator_enable <= `RST_MOD_EN;
      o_fb_modulator_order <= `RST_MOD_ORDER;
    end else begin
      o_fb_divide <= fb_divide;
      // Reserved baseline codes are not blocked; sum still fits six bits
      o_dac_code <= {1'b0, dac_baseline_r} + {1'b0, i_dac_modulation};
      o_fb_modulator_enable <= fb_modulator_enable_r;
      o_fb_modulator_order <= fb_modulator_order_r;
    end
  end

endmodule // tdc_apll_and_sysclk_divider_cfg

//--- rtl/tdc_cfg_defs.vh
// Register indices, field layouts and reset values of the converter clock configuration
`ifndef TDC_CFG_DEFS_VH
`define TDC_CFG_DEFS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ADDR_REF_PREDIVIDE 8'h00
`define ADDR_FB_MOD_CTRL 8'h01
`define ADDR_FB_INTEGER 8'h02
`define ADDR_FB_FRAC_LO 8'h03
`define ADDR_FB_FRAC_HI 8'h04
`define ADDR_DAC_BASELINE 8'h05
`define ADDR_SYS_DIVIDE 8'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PREDIV_MSB 2
`define MOD_EN_BIT 7
`define MOD_ORDER_MSB 1
`define DAC_BASE_MSB 4
`define SYS_DIV_MSB 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PREDIV 3'h1
`define RST_MOD_EN 1'h1
`define RST_MOD_ORDER 2'h1
`define RST_FB_INTEGER 8'h23
`define RST_FB_FRAC 16'h2800
`define RST_DAC_BASE 5'h04
`define RST_SYS_DIV 5'h0c

// ----------------------------------------------------------------
// Encodings and fixed ratios
// ----------------------------------------------------------------
`define PREDIV_BYPASS 3'h0
`define PREDIV_MAX_CODE 3'h4
`define ORDER_INTEGER 2'h0
`define ORDER_FIRST 2'h1
`define ORDER_SECOND 2'h2
`define SYS_PRESCALE 8'h04

`endif

//--- rtl/edge_divider.v
// Counts input pulses and emits one pulse per programmed ratio
`timescale 1ns/1ps
module edge_divider (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire i_bypass,
  input wire [7:0] i_ratio,
  // Pulses
  input wire i_pulse,
  output reg o_pulse
);

  reg [7:0] cnt_r;

  // Ratio change mid-count applies to the running count; if already passed, the next pulse fires and clears the count
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= 1'b0;
      if (i_pulse) begin
        if (i_bypass || (cnt_r + 8'h01 >= i_ratio)) begin
          cnt_r <= 8'h00;
          o_pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end

endmodule // edge_divider

//--- rtl/fb_modulator.v
// Sigma-delta modulator producing the per-cycle feedback divide value
`timescale 1ns/1ps
`include "tdc_cfg_defs.vh"
module fb_modulator (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Configuration
  input wire i_enable,
  input wire [1:0] i_order,
  input wire [7:0] i_integer,
  input wire [15:0] i_fraction,
  // Feedback cycle strobe and result
  input wire i_fb_strobe,
  output reg [9:0] o_divide
);

  reg [15:0] acc1_r;
  reg [15:0] acc2_r;
  reg carry2_prev_r;
  reg [16:0] sum1;
  reg [16:0] sum2;
  reg [9:0] div_nxt;

  always @* begin
    sum1 = {1'b0, acc1_r} + {1'b0, i_fraction};
    sum2 = {1'b0, acc2_r} + {1'b0, sum1[15:0]};
    div_nxt = {2'b00, i_integer};
    if (i_enable) begin
      case (i_order)
        `ORDER_FIRST: begin
          div_nxt = {2'b00, i_integer} + {9'h000, sum1[16]};
        end
        `ORDER_SECOND: begin
          // Second stage differentiated carry keeps the mean at int + frac
          div_nxt = {2'b00, i_integer} + {9'h000, sum1[16]} + {9'h000, sum2[16]}
            - {9'h000, carry2_prev_r};
        end
        default: begin
          div_nxt = {2'b00, i_integer};
        end
      endcase
    end
  end

  // Fraction over two to the sixteenth via 16-bit accumulator overflow
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc1_r <= 16'h0000;
      acc2_r <= 16'h0000;
      carry2_prev_r <= 1'b0;
      o_divide <= {2'b00, `RST_FB_INTEGER};
    end else if (i_fb_strobe) begin
      o_divide <= div_nxt;
      if (i_enable && (i_order == `ORDER_FIRST || i_order == `ORDER_SECOND)) begin
        acc1_r <= sum1[15:0];
        acc2_r <= (i_order == `ORDER_SECOND) ? sum2[15:0] : 16'h0000;
        carry2_prev_r <= (i_order == `ORDER_SECOND) ? sum2[16] : 1'b0;
      end else begin
        acc1_r <= 16'h0000;
        acc2_r <= 16'h0000;
        carry2_prev_r <= 1'b0;
      end
    end
  end

endmodule // fb_modulator

//--- bench/tdc_cfg_asserts.sv
// Port-level checks for the converter clock configuration block
`timescale 1ns/1ps
module tdc_cfg_asserts (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Register access
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  // Datapath
  input wire o_ref_div_pulse,
  input wire o_ref_div_clk,
  input wire i_fb_strobe,
  input wire [9:0] o_fb_divide,
  input wire [4:0] i_dac_modulation,
  input wire [5:0] o_dac_code,
  input wire o_sys_tick,
  input wire o_fb_modulator_enable,
  input wire [1:0] o_fb_modulator_order
);
  // ----------------------------------------------------------------
  // Shadow copies of fields the outputs depend on
  // ----------------------------------------------------------------
  reg [4:0] base_r;
  reg [7:0] int_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_r <= 5'h04;
      int_r <= 8'h23;
    end else if (i_wr_en) begin
      if (i_addr == 8'h05)
        base_r <= i_wdata[4:0];
      if (i_addr == 8'h02)
        int_r <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rdata_hold: assert property (!i_rd_en |=> $stable(o_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property ((i_rd_en && i_addr > 8'h06) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property ((i_rd_en && i_addr == 8'h01) |=> o_rdata[6:2] == 5'h00)
    else $error("reserved control bits not zero");
  // First edge after release still sees reset values in the past terms
  a_dac_sum: assert property ($past(i_rst_n) |->
    o_dac_code == $past(base_r) + $past(i_dac_modulation))
    else $error("dac code not baseline plus modulation");
  a_mod_copy: assert property ((i_wr_en && i_addr == 8'h01) |-> ##2
    {o_fb_modulator_enable, o_fb_modulator_order} ==
    {$past(i_wdata[7], 2), $past(i_wdata[1:0], 2)})
    else $error("modulator config view wrong");
  a_fb_integer: assert property ((i_fb_strobe && !o_fb_modulator_enable) |-> ##3
    o_fb_divide == {2'h0, $past(int_r, 3)})
    else $error("disabled modulator not integer");
  a_sys_spacing: assert property (o_sys_tick |=> !o_sys_tick [*7])
    else $error("system ticks too close");
  a_ref_single: assert property (o_ref_div_pulse |=> !o_ref_div_pulse)
    else $error("reference pulse too long");
  a_ref_clk_toggle: assert property ($changed(o_ref_div_clk) |->
    (o_ref_div_pulse || $past(o_ref_div_pulse)))
    else $error("reference clock moved without pulse");
endmodule // tdc_cfg_asserts

bind tdc_apll_and_sysclk_divider_cfg tdc_cfg_asserts u_chk (.i_clk, .i_rst_n, .i_wr_en,
  .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_ref_div_pulse, .o_ref_div_clk, .i_fb_strobe,
  .o_fb_divide, .i_dac_modulation, .o_dac_code, .o_sys_tick, .o_fb_modulator_enable,
  .o_fb_modulator_order);

//--- bench/testbench.sv
// Self-checking bench for the converter clock configuration block
`timescale 1ns/1ps
module testbench;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_wr_en = 1'b0;
  reg i_rd_en = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [7:0] i_wdata = 8'h00;
  reg i_ref_in = 1'b0;
  reg i_clkin = 1'b0;
  reg i_apll_ref_sel = 1'b0;
  reg i_fb_strobe = 1'b0;
  reg [4:0] i_dac_modulation = 5'h00;
  reg i_osc_tick = 1'b0;
  wire [7:0] o_rdata;
  wire o_ref_div_pulse;
  wire o_ref_div_clk;
  wire [9:0] o_fb_divide;
  wire [5:0] o_dac_code;
  wire o_sys_tick;
  wire o_fb_modulator_enable;
  wire [1:0] o_fb_modulator_order;
  integer miscompares = 0;
  integer n_compared = 0;
  integer cycles = 0;
  integer ref_cnt = 0;
  integer sys_cnt = 0;
  integer i, a, b, sum;

  always #20 i_clk = ~i_clk;

  tdc_apll_and_sysclk_divider_cfg u_dut (.i_clk, .i_rst_n, .i_wr_en, .i_rd_en, .i_addr,
    .i_wdata, .o_rdata, .i_ref_in, .i_clkin, .i_apll_ref_sel, .o_ref_div_pulse,
    .o_ref_div_clk, .i_fb_strobe, .o_fb_divide, .i_dac_modulation, .o_dac_code,
    .i_osc_tick, .o_sys_tick, .o_fb_modulator_enable, .o_fb_modulator_order);

  // ----------------------------------------------------------------
  // Monitors and hang guard
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_ref_div_pulse)
      ref_cnt <= ref_cnt + 1;
    if (o_sys_tick)
      sys_cnt <= sys_cnt + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task finish_test;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge i_clk);
  endtask
  task rst;
    begin
      i_rst_n = 1'b0;
      cyc(8);
      i_rst_n = 1'b1;
    end
  endtask
  // Gap cycle after each write keeps config writes apart
  task wr(input [7:0] ad, input [7:0] d);
    begin
      i_addr = ad;
      i_wdata = d;
      i_wr_en = 1'b1;
      cyc(1);
      i_wr_en = 1'b0;
      cyc(1);
    end
  endtask
  task rc(input [7:0] ad, input [7:0] e);
    begin
      i_addr = ad;
      i_rd_en = 1'b1;
      cyc(1);
      i_rd_en = 1'b0;
      cyc(1);
      chk(o_rdata, e);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    begin
      rc(8'h00, 8'h01);
      rc(8'h01, 8'h81);
      rc(8'h02, 8'h23);
      rc(8'h03, 8'h00);
      rc(8'h04, 8'h28);
      rc(8'h05, 8'h04);
      rc(8'h06, 8'h0c);
      for (i = 0; i < 5; i = i + 1)
        wr(i[7:0], 8'hff);
      wr(8'h05, 8'hf0);
      wr(8'h06, 8'hef);
      wr(8'h07, 8'hff);
      rc(8'h00, 8'h07);
      rc(8'h01, 8'h83);
      rc(8'h02, 8'hff);
      rc(8'h03, 8'hff);
      rc(8'h04, 8'hff);
      rc(8'h05, 8'h10);
      rc(8'h06, 8'h0f);
      rc(8'h07, 8'h00);
      for (i = 0; i < 6; i = i + 1)
        wr(i[7:0], 8'h00);
      wr(8'h06, 8'h0a);
      wr(8'h07, 8'h00);
      for (i = 0; i < 6; i = i + 1)
        rc(i[7:0], 8'h00);
      rc(8'h06, 8'h0a);
      rc(8'h07, 8'h00);
      $display("regs done");
    end
  endtask
  task t_ref(input [2:0] c, input s, input p, input [15:0] e);
    begin
      rst;
      wr(8'h00, {5'h00, c});
      i_apll_ref_sel = s;
      cyc(4);
      ref_cnt = 0;
      repeat (32) begin
        if (p)
          i_clkin = 1'b1;
        else
          i_ref_in = 1'b1;
        cyc(2);
        i_clkin = 1'b0;
        i_ref_in = 1'b0;
        cyc(2);
      end
      cyc(8);
      chk(ref_cnt, e);
      $display("ref done");
    end
  endtask
  task strobe;
    begin
      i_fb_strobe = 1'b1;
      cyc(1);
      i_fb_strobe = 1'b0;
      cyc(3);
      sum = sum + o_fb_divide;
    end
  endtask
  // Earlier runs leave the accumulators at zero, so sums are exact within one step
  task t_fb(input [7:0] ctl, input [15:0] f, input integer n, input integer e,
            input integer tol);
    begin
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h30);
      wr(8'h03, f[7:0]);
      wr(8'h04, f[15:8]);
      wr(8'h01, ctl);
      sum = 0;
      repeat (n) strobe;
      chk(sum + tol >= e && sum <= e + tol, 16'h0001);
      chk({o_fb_modulator_enable, o_fb_modulator_order}, {ctl[7], ctl[1:0]});
      $display("fb done");
    end
  endtask
  task t_dac(input [4:0] bs, input [4:0] m);
    begin
      wr(8'h05, {3'h0, bs});
      i_dac_modulation = m;
      cyc(2);
      chk(o_dac_code, {1'b0, bs} + m);
      $display("dac done");
    end
  endtask
  task t_sys(input [4:0] n);
    begin
      rst;
      wr(8'h06, {3'h0, n});
      sys_cnt = 0;
      a = -1;
      b = -1;
      for (i = 0; i < 140; i = i + 1) begin
        i_osc_tick = 1'b1;
        cyc(2);
        i_osc_tick = 1'b0;
        cyc(2);
        if (sys_cnt == 1 && a < 0)
          a = i;
        if (sys_cnt == 2 && b < 0)
          b = i;
      end
      chk(b - a, 4 * n);
      $display("sys done");
    end
  endtask

  initial begin
    rst;
    t_regs;
    for (i = 0; i < 5; i = i + 1)
      t_ref(i[2:0], 1'b0, 1'b0, 16'd32 >> i);
    t_ref(3'h0, 1'b1, 1'b1, 16'd32);
    t_ref(3'h0, 1'b1, 1'b0, 16'd0);
    t_ref(3'h0, 1'b0, 1'b1, 16'd0);
    t_fb(8'h01, 16'h8000, 8, 384, 0);
    t_fb(8'h80, 16'h8000, 8, 384, 0);
    t_fb(8'h83, 16'h8000, 8, 384, 0);
    t_fb(8'h81, 16'h8000, 16, 776, 1);
    t_fb(8'h82, 16'h4000, 16, 772, 1);
    t_dac(5'h10, 5'h10);
    t_dac(5'h00, 5'h00);
    t_dac(5'h0a, 5'h07);
    t_sys(5'd10);
    t_sys(5'd15);
    finish_test;
  end
endmodule // testbench
